// *** core/mio_pkg.sv ***
// Purpose: shared constants and types for the motion i/o conditioning block
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes: sync vector slice positions are listed here so all files agree

// ****************************************************************
// constants
// ****************************************************************
package mio_pkg;
  localparam int NUM_AXES = 8;
  localparam int CMD_W = 16;
  localparam int ADC_W = 12;
  localparam int AN_CH = 7;
  localparam int AN_SEL_W = 3;
  localparam int OUT_W = 16;
  localparam int OUT_BIT_W = 4;
  localparam int GEN_IN_W = 16;
  localparam int TTL_IN_W = 8;
  localparam int CHAR_W = 8;
  localparam int BUF_DEPTH = 512;
  localparam int BUF_CNT_W = 10;
  localparam int IO_ADDR_W = 10;
  localparam int BASE_SEL_W = 7;
  localparam logic [IO_ADDR_W-1:0] IO_BASE_MIN = 10'h200;
  localparam logic [IO_ADDR_W-1:0] IO_CTL_OFS = 10'h001;
  localparam logic [3:0] AXES_EXT_MIN = 4'h5;
  // control register status bits
  localparam int CTL_AF_BIT = 4;
  localparam int CTL_EMPTY_BIT = 5;
  localparam int CTL_CLR_BIT = 7;
  // control register command bytes
  localparam logic [CHAR_W-1:0] CTL_SET_LEVEL = 8'h05;
  localparam logic [CHAR_W-1:0] CTL_CLR_A = 8'h01;
  localparam logic [CHAR_W-1:0] CTL_CLR_B = 8'h80;
  localparam logic [CHAR_W-1:0] EMPTY_READ = 8'hFF;
  localparam logic [1:0] CLR_LAST_STEP = 2'h3;
  localparam logic [BUF_CNT_W-1:0] AF_LEVEL_RST = 10'h010;
  // polarity: 0 = active low (default), 1 = active high
  localparam logic POL_RST = 1'b0;
  // synchroniser vector layout, reset value all ones (open input reads one)
  localparam int SY_RST = 0;
  localparam int SY_FWD = 1;
  localparam int SY_REV = 9;
  localparam int SY_HOME = 17;
  localparam int SY_LATCH = 25;
  localparam int SY_ABORT = 33;
  localparam int SY_GEN = 34;
  localparam int SY_TTL = 50;
  localparam int SYNC_W = 58;

  typedef enum logic [1:0] {
    MIO_OUT_SET = 2'b00,
    MIO_OUT_CLR = 2'b01,
    MIO_OUT_BIT = 2'b10,
    MIO_OUT_PORT = 2'b11
  } mio_out_op_t;

  typedef enum logic [0:0] {
    MIO_CTL_IDLE = 1'b0,
    MIO_CTL_LEVEL = 1'b1
  } mio_ctl_state_t;
endpackage

// *** core/mio_stream_if.sv ***
// Purpose: valid/ready character stream between block modules
// Assumes: same clock on both ends
// Notes: transfer when valid and ready are both high at an edge
`timescale 1ns/10ps

// ****************************************************************
// stream interface
// ****************************************************************
interface mio_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** core/mio_fifo.sv ***
// Purpose: parameterised fifo with registered read data
// Assumes: write and read on mclk; flush empties it in one edge
// Notes: ready on the write side is a flop, low exactly when full
`timescale 1ns/10ps

// ****************************************************************
// fifo
// ****************************************************************
module mio_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int CNT_W = 6
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  input wire logic flush,
  // streams
  mio_stream_if.snk wr,
  mio_stream_if.src rd,
  // fill level, memory plus output stage
  output logic [CNT_W-1:0] level
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [CNT_W-1:0] count_reg, count_next;
  logic in_ready_reg, in_ready_next, out_valid_reg, out_valid_next;
  logic [WIDTH-1:0] out_data_reg;
  logic push, load;

  // handshake terms
  assign push = wr.valid && in_ready_reg;
  assign load = (count_reg != '0) && (!out_valid_reg || rd.ready);
  assign wr.ready = in_ready_reg;
  assign rd.valid = out_valid_reg;
  assign rd.data = out_data_reg;
  assign level = count_reg + CNT_W'(out_valid_reg);

  // next pointers, count and flags
  always_comb
  begin
    wr_ptr_next = wr_ptr_reg + PTR_W'(push);
    rd_ptr_next = rd_ptr_reg + PTR_W'(load);
    count_next = count_reg + CNT_W'(push) - CNT_W'(load);
    out_valid_next = load || (out_valid_reg && !rd.ready);
    if (flush)
    begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      count_next = '0;
      out_valid_next = 1'b0;
    end
    in_ready_next = count_next < CNT_W'(DEPTH);
  end

  // state registers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready_reg <= 1'b1;
      out_valid_reg <= 1'b0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      in_ready_reg <= in_ready_next;
      out_valid_reg <= out_valid_next;
    end
  end

  // storage and registered read port
  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr_reg] <= wr.data;
    if (load)
      out_data_reg <= mem[rd_ptr_reg];
  end

  fifo_count_a: assert property (@(posedge mclk) disable iff (reset)
    (push && !load && !flush) |=> (count_reg == $past(count_reg) + CNT_W'(1)))
    else $error("fifo count did not rise on push");

  fifo_full_a: assert property (@(posedge mclk) disable iff (reset)
    (count_reg == CNT_W'(DEPTH)) |-> !in_ready_reg)
    else $error("fifo accepts data while full");
endmodule

// *** core/mio_top.sv ***
// Purpose: input conditioning, amp enable, error, outputs and host char link
// Assumes: inputs synchronous to mclk per port; io strobes one cycle wide
// Notes: all top outputs come from flops; buffers are 512 deep
`timescale 1ns/10ps

// ****************************************************************
// top module
// ****************************************************************
// Behaviour
// - open inputs read as logic one
// - default limit active when input low
// - settable polarity for limit, home, latch
// - abort sense fixed, ignores polarity
// - amp enable drops on three events
// - amp enable output active high
// - error output low while any error
// - error led on with error output
// - sixteen general outputs, set/clear/bit/port, readback
// - five or more axes add upper outputs
// - five or more axes add ttl inputs
// - local reset input resets controller and drives error output low
// - seven analog channels, twelve bit results
// - motor off zeroes axis motor command
// - handshaked ascii receive and transmit registers
// - 512 entry write fifo, 512 read buffer
// - decoded in host io space only
module mio_top
  import mio_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // external switch and ttl inputs
  input wire logic [NUM_AXES-1:0] forward_limit_in,
  input wire logic [NUM_AXES-1:0] reverse_limit_in,
  input wire logic [NUM_AXES-1:0] home_switch_in,
  input wire logic [NUM_AXES-1:0] latch_in,
  input wire logic abort_in,
  input wire logic [GEN_IN_W-1:0] general_input,
  input wire logic [TTL_IN_W-1:0] ttl_input,
  input wire logic local_reset_in_n,
  input wire logic [3:0] num_axes,
  // polarity command
  input wire logic input_polarity_cmd,
  input wire logic limit_pol,
  input wire logic home_pol,
  input wire logic latch_pol,
  // servo controls
  input wire logic watchdog_timeout,
  input wire logic motor_off_cmd,
  input wire logic motor_on_cmd,
  input wire logic [NUM_AXES-1:0] motor_axis_mask,
  input wire logic off_on_error_enable_cmd,
  input wire logic off_on_error_value,
  input wire logic [NUM_AXES-1:0] pos_error_over,
  input wire logic cpu_fault_reset,
  input wire logic [NUM_AXES*CMD_W-1:0] servo_command,
  // general output commands
  input wire logic out_cmd_valid,
  input wire mio_out_op_t out_cmd_op,
  input wire logic [OUT_BIT_W-1:0] out_cmd_bit,
  input wire logic out_cmd_value,
  input wire logic out_cmd_port,
  input wire logic [7:0] out_cmd_byte,
  // converter results
  input wire logic adc_valid,
  input wire logic [AN_SEL_W-1:0] adc_channel,
  input wire logic [ADC_W-1:0] adc_data,
  // host io bus
  input wire logic [IO_ADDR_W-1:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic io_dma_cycle,
  input wire logic [CHAR_W-1:0] io_wdata,
  input wire logic [BASE_SEL_W-1:0] base_sel,
  // controller character streams
  input wire logic cmd_char_ready,
  input wire logic resp_char_valid,
  input wire logic [CHAR_W-1:0] resp_char_data,
  // conditioned status
  output logic [NUM_AXES-1:0] fwd_limit_active,
  output logic [NUM_AXES-1:0] rev_limit_active,
  output logic [NUM_AXES-1:0] home_active,
  output logic [NUM_AXES-1:0] latch_active,
  output logic abort_active,
  output logic [GEN_IN_W+TTL_IN_W-1:0] general_input_state,
  output logic local_reset_out,
  // amplifier and error
  output logic [NUM_AXES-1:0] amp_enable_out,
  output logic [NUM_AXES*CMD_W-1:0] motor_command_voltage,
  output logic error_out_n,
  output logic error_led,
  // general outputs
  output logic [OUT_W-1:0] general_output,
  output logic [OUT_W-1:0] output_port_readback,
  // analog results
  output logic [AN_CH*ADC_W-1:0] analog_channel,
  // host and controller side
  output logic [CHAR_W-1:0] io_rdata,
  output logic host_overrun,
  output logic cmd_char_valid,
  output logic [CHAR_W-1:0] cmd_char_data,
  output logic resp_char_ready
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [SYNC_W-1:0] sync_raw, sync1_reg, sync2_reg;
  logic ext_axes;

  assign sync_raw = {ttl_input, general_input, abort_in, latch_in, home_switch_in,
                     reverse_limit_in, forward_limit_in, local_reset_in_n};
  assign ext_axes = num_axes >= AXES_EXT_MIN;

  // reset to one, open reads one
  for (genvar b = 0; b < SYNC_W; b++)
  begin : g_sync
    always_ff @(posedge mclk)
    begin
      if (reset)
      begin
        sync1_reg[b] <= 1'b1;
        sync2_reg[b] <= 1'b1;
      end
      else
      begin
        sync1_reg[b] <= sync_raw[b];
        sync2_reg[b] <= sync1_reg[b];
      end
    end
  end

  // ****************************************************************
  // polarity and input status
  // ****************************************************************
  logic limit_pol_reg, limit_pol_next, home_pol_reg, home_pol_next;
  logic latch_pol_reg, latch_pol_next;

  always_comb
  begin
    limit_pol_next = limit_pol_reg;
    home_pol_next = home_pol_reg;
    latch_pol_next = latch_pol_reg;
    if (input_polarity_cmd)
    begin
      limit_pol_next = limit_pol;
      home_pol_next = home_pol;
      latch_pol_next = latch_pol;
    end
  end

  // status from synchronised levels
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      limit_pol_reg <= POL_RST;
      home_pol_reg <= POL_RST;
      latch_pol_reg <= POL_RST;
      fwd_limit_active <= '0;
      rev_limit_active <= '0;
      home_active <= '0;
      latch_active <= '0;
      abort_active <= 1'b0;
      general_input_state <= '1;
      local_reset_out <= 1'b0;
    end
    else
    begin
      limit_pol_reg <= limit_pol_next;
      home_pol_reg <= home_pol_next;
      latch_pol_reg <= latch_pol_next;
      fwd_limit_active <= limit_pol_reg ? sync2_reg[SY_FWD +: NUM_AXES]
                                        : ~sync2_reg[SY_FWD +: NUM_AXES];
      rev_limit_active <= limit_pol_reg ? sync2_reg[SY_REV +: NUM_AXES]
                                        : ~sync2_reg[SY_REV +: NUM_AXES];
      home_active <= home_pol_reg ? sync2_reg[SY_HOME +: NUM_AXES]
                                  : ~sync2_reg[SY_HOME +: NUM_AXES];
      latch_active <= latch_pol_reg ? sync2_reg[SY_LATCH +: NUM_AXES]
                                    : ~sync2_reg[SY_LATCH +: NUM_AXES];
      abort_active <= ~sync2_reg[SY_ABORT];
      // ttl inputs only with extended axes
      general_input_state <= {ext_axes ? sync2_reg[SY_TTL +: TTL_IN_W] : {TTL_IN_W{1'b0}},
                              sync2_reg[SY_GEN +: GEN_IN_W]};
      local_reset_out <= ~sync2_reg[SY_RST];
    end
  end

  // ****************************************************************
  // amplifier enable, motor command, error
  // ****************************************************************
  logic [NUM_AXES-1:0] amp_on_next, oe_reg, oe_next;
  logic err_any;

  always_comb
  begin
    oe_next = oe_reg;
    amp_on_next = amp_enable_out;
    if (off_on_error_enable_cmd)
      oe_next = off_on_error_value ? (oe_reg | motor_axis_mask) : (oe_reg & ~motor_axis_mask);
    if (motor_on_cmd)
      amp_on_next = amp_on_next | motor_axis_mask;
    if (motor_off_cmd)
      amp_on_next = amp_on_next & ~motor_axis_mask;
    amp_on_next = amp_on_next & ~(oe_reg & pos_error_over);
    if (watchdog_timeout)
      amp_on_next = '0;
  end

  assign err_any = (|pos_error_over) || !sync2_reg[SY_RST] || cpu_fault_reset;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      oe_reg <= '0;
      amp_enable_out <= '0;
      error_out_n <= 1'b1;
      error_led <= 1'b0;
    end
    else
    begin
      oe_reg <= oe_next;
      amp_enable_out <= amp_on_next;
      error_out_n <= !err_any;
      error_led <= err_any;
    end
  end

  for (genvar a = 0; a < NUM_AXES; a++)
  begin : g_axis
    always_ff @(posedge mclk)
    begin
      if (reset)
        motor_command_voltage[a*CMD_W +: CMD_W] <= '0;
      else
        motor_command_voltage[a*CMD_W +: CMD_W] <= amp_on_next[a] ?
                                                   servo_command[a*CMD_W +: CMD_W] : '0;
    end

    cmd_zero_a: assert property (@(posedge mclk) disable iff (reset)
      (motor_off_cmd && motor_axis_mask[a]) |=> (motor_command_voltage[a*CMD_W +: CMD_W] == '0))
      else $error("motor command not zeroed after motor off");
  end

  // ****************************************************************
  // general outputs and analog results
  // ****************************************************************
  logic [OUT_W-1:0] gen_out_next;

  always_comb
  begin
    gen_out_next = general_output;
    if (out_cmd_valid)
    begin
      unique case (out_cmd_op)
        MIO_OUT_SET: gen_out_next[out_cmd_bit] = 1'b1;
        MIO_OUT_CLR: gen_out_next[out_cmd_bit] = 1'b0;
        MIO_OUT_BIT: gen_out_next[out_cmd_bit] = out_cmd_value;
        MIO_OUT_PORT: gen_out_next[out_cmd_port*8 +: 8] = out_cmd_byte;
      endcase
    end
    // upper byte only with extended axes
    if (!ext_axes)
      gen_out_next[OUT_W-1:8] = '0;
  end

  // output and readback registers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      general_output <= '0;
      output_port_readback <= '0;
    end
    else
    begin
      general_output <= gen_out_next;
      output_port_readback <= gen_out_next;
    end
  end

  // per channel result store, channels 1 to 7
  for (genvar c = 0; c < AN_CH; c++)
  begin : g_adc
    always_ff @(posedge mclk)
    begin
      if (reset)
        analog_channel[c*ADC_W +: ADC_W] <= '0;
      else if (adc_valid && adc_channel == AN_SEL_W'(c + 1))
        analog_channel[c*ADC_W +: ADC_W] <= adc_data;
    end
  end

  // ****************************************************************
  // host character link
  // ****************************************************************
  mio_stream_if #(.WIDTH(CHAR_W)) wf_in();
  mio_stream_if #(.WIDTH(CHAR_W)) wf_out();
  mio_stream_if #(.WIDTH(CHAR_W)) rf_in();
  mio_stream_if #(.WIDTH(CHAR_W)) rf_out();
  logic [BUF_CNT_W-1:0] wf_level, af_level_reg, af_level_next;
  logic [IO_ADDR_W-1:0] base_addr;
  logic sel_data, sel_ctl, flush_reg, flush_next, clr_done_reg, clr_done_next;
  logic overrun_next;
  logic [1:0] clr_step_reg, clr_step_next;
  logic [CHAR_W-1:0] rdata_next;
  mio_ctl_state_t ctl_state_reg, ctl_state_next;

  mio_fifo #(.WIDTH(CHAR_W), .DEPTH(BUF_DEPTH), .CNT_W(BUF_CNT_W)) u_wfifo (
    .mclk(mclk), .reset(reset), .flush(flush_reg),
    .wr(wf_in), .rd(wf_out), .level(wf_level));

  mio_fifo #(.WIDTH(CHAR_W), .DEPTH(BUF_DEPTH), .CNT_W(BUF_CNT_W)) u_rfifo (
    .mclk(mclk), .reset(reset), .flush(flush_reg),
    .wr(rf_in), .rd(rf_out), .level());

  // io space decode, ignored in dma cycles
  assign base_addr = IO_BASE_MIN + IO_ADDR_W'({base_sel, 2'b00});
  assign sel_data = !io_dma_cycle && (io_addr == base_addr);
  assign sel_ctl = !io_dma_cycle && (io_addr == base_addr + IO_CTL_OFS);

  // host writes and reads, handshake through fifos
  assign wf_in.valid = sel_data && io_wr;
  assign wf_in.data = io_wdata;
  assign rf_out.ready = sel_data && io_rd;
  assign rf_in.valid = resp_char_valid;
  assign rf_in.data = resp_char_data;
  assign wf_out.ready = cmd_char_ready;

  // control register and read data
  always_comb
  begin
    ctl_state_next = ctl_state_reg;
    af_level_next = af_level_reg;
    clr_step_next = clr_step_reg;
    clr_done_next = clr_done_reg;
    flush_next = 1'b0;
    overrun_next = host_overrun || (wf_in.valid && !wf_in.ready);
    rdata_next = io_rdata;
    if (sel_ctl && io_rd)
    begin
      clr_step_next = '0;
      rdata_next = '0;
      rdata_next[CTL_CLR_BIT] = clr_done_reg;
      rdata_next[CTL_EMPTY_BIT] = !rf_out.valid;
      rdata_next[CTL_AF_BIT] = wf_level >= af_level_reg;
    end
    else if (sel_data && io_rd)
      rdata_next = rf_out.valid ? rf_out.data : EMPTY_READ;
    if (sel_ctl && io_wr)
    begin
      clr_done_next = 1'b0;
      unique case (ctl_state_reg)
        MIO_CTL_IDLE:
        begin
          if (io_wdata == CTL_SET_LEVEL)
          begin
            ctl_state_next = MIO_CTL_LEVEL;
            clr_step_next = '0;
          end
          else if (io_wdata == (clr_step_reg[0] ? CTL_CLR_B : CTL_CLR_A))
          begin
            clr_step_next = clr_step_reg + 2'h1;
            if (clr_step_reg == CLR_LAST_STEP)
            begin
              flush_next = 1'b1;
              clr_done_next = 1'b1;
              overrun_next = 1'b0;
            end
          end
          else
            clr_step_next = (io_wdata == CTL_CLR_A) ? 2'h1 : 2'h0;
        end
        MIO_CTL_LEVEL:
        begin
          af_level_next = AF_LEVEL_RST + BUF_CNT_W'(io_wdata);
          ctl_state_next = MIO_CTL_IDLE;
        end
      endcase
    end
  end

  // host side registers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ctl_state_reg <= MIO_CTL_IDLE;
      af_level_reg <= AF_LEVEL_RST;
      clr_step_reg <= '0;
      clr_done_reg <= 1'b0;
      flush_reg <= 1'b0;
      host_overrun <= 1'b0;
      io_rdata <= EMPTY_READ;
    end
    else
    begin
      ctl_state_reg <= ctl_state_next;
      af_level_reg <= af_level_next;
      clr_step_reg <= clr_step_next;
      clr_done_reg <= clr_done_next;
      flush_reg <= flush_next;
      host_overrun <= overrun_next;
      io_rdata <= rdata_next;
    end
  end

  // fifo flops as stream outputs
  assign cmd_char_valid = wf_out.valid;
  assign cmd_char_data = wf_out.data;
  assign resp_char_ready = rf_in.ready;

  // ****************************************************************
  // checks
  // ****************************************************************
  // motor off drops enable
  amp_off_a: assert property (@(posedge mclk) disable iff (reset)
    motor_off_cmd |=> ((amp_enable_out & $past(motor_axis_mask)) == '0))
    else $error("amp enable stayed on after motor off");

  wdog_drop_a: assert property (@(posedge mclk) disable iff (reset)
    watchdog_timeout |=> (amp_enable_out == '0))
    else $error("amp enable on after watchdog");

  err_out_a: assert property (@(posedge mclk) disable iff (reset)
    (|pos_error_over) |=> !error_out_n)
    else $error("error output not low on position error");

  led_follow_a: assert property (@(posedge mclk) disable iff (reset)
    error_led == !error_out_n)
    else $error("error led disagrees with error output");

  abort_fixed_a: assert property (@(posedge mclk) disable iff (reset)
    (!abort_in)[*3] |=> abort_active)
    else $error("low abort input not seen active");

  limit_low_a: assert property (@(posedge mclk) disable iff (reset)
    (!limit_pol_reg && !forward_limit_in[0])[*3] |=> fwd_limit_active[0])
    else $error("low limit not seen active");

  out_set_a: assert property (@(posedge mclk) disable iff (reset)
    (out_cmd_valid && out_cmd_op == MIO_OUT_SET && out_cmd_bit < 4'h8)
    |=> output_port_readback[$past(out_cmd_bit)])
    else $error("set bit not in readback");

  empty_read_a: assert property (@(posedge mclk) disable iff (reset)
    (sel_data && io_rd && !rf_out.valid) |=> (io_rdata == EMPTY_READ))
    else $error("empty read did not return ff");

  io_space_a: assert property (@(posedge mclk) disable iff (reset)
    io_dma_cycle |-> !wf_in.valid)
    else $error("write taken during dma cycle");
endmodule

// *** test/mio_proc_model.sv ***
// Purpose: processor side of the char streams
// Assumes: shares mclk with the block
// Notes: stalls its ready at random
`timescale 1ns/10ps
module mio_proc_model (
  // clock
  input wire logic mclk,
  // streams
  input wire logic cmd_char_valid,
  input wire logic [7:0] cmd_char_data,
  output logic cmd_char_ready,
  input wire logic resp_char_ready,
  output logic resp_char_valid,
  output logic [7:0] resp_char_data,
  // bench side
  input wire logic send,
  input wire logic [7:0] send_data,
  output logic [7:0] got
);
  initial {cmd_char_ready, resp_char_valid, resp_char_data, got} = '0;
  always @(posedge mclk)
  begin
    if (cmd_char_valid && cmd_char_ready) got <= cmd_char_data;
    cmd_char_ready <= 1'($urandom_range(1, 0));
    if (send) resp_char_data <= send_data;
    if (send) resp_char_valid <= 1'h1;
    else if (resp_char_ready && resp_char_valid)
    begin
      resp_char_valid <= 1'h0;
      resp_char_data <= ~resp_char_data;
    end
  end
endmodule

// *** test/mio_top_tb.sv ***
// Purpose: self-checking bench for mio_top
// Assumes: base_sel 0, so N is 10'h200
// Notes: random chars and levels
`timescale 1ns/10ps
module mio_top_tb;
  import mio_pkg::*;
  logic mclk = 0, reset = 1, abort_in = 1, local_reset_in_n = 1, input_polarity_cmd = 0;
  logic limit_pol = 0, home_pol = 0, latch_pol = 0, watchdog_timeout = 0, motor_off_cmd = 0;
  logic motor_on_cmd = 0, cpu_fault_reset = 0, off_on_error_enable_cmd = 0, send = 0;
  logic off_on_error_value = 0, out_cmd_valid = 0, out_cmd_value = 0, out_cmd_port = 0;
  logic adc_valid = 0, io_rd = 0, io_wr = 0, io_dma_cycle = 0, abort_active, local_reset_out;
  logic [7:0] forward_limit_in = '1, reverse_limit_in = '1, home_switch_in = '1, latch_in = '1;
  logic [7:0] motor_axis_mask = '1, pos_error_over = '0, out_cmd_byte = '0, ttl_input = '1;
  logic [7:0] io_wdata = '0, send_data = '0, got, c, io_rdata, cmd_char_data, resp_char_data;
  logic [7:0] fwd_limit_active, rev_limit_active, home_active, latch_active, amp_enable_out;
  logic [15:0] general_input = '1, general_output, output_port_readback;
  logic [3:0] num_axes = 4'h8, out_cmd_bit = '0;
  mio_out_op_t out_cmd_op = MIO_OUT_SET;
  logic [2:0] adc_channel = '0;
  logic [11:0] adc_data = '0;
  logic [9:0] io_addr = 10'h200;
  logic [6:0] base_sel = '0;
  logic [127:0] servo_command = '1, motor_command_voltage;
  logic [83:0] analog_channel;
  logic [23:0] general_input_state;
  logic error_out_n, error_led, host_overrun, cmd_char_valid, cmd_char_ready;
  logic resp_char_valid, resp_char_ready;
  int n_fail = 0, cmp_count = 0;
  mio_top dut_u (.*);
  mio_proc_model pm_u (.*);
  initial forever #25 mclk = ~mclk;
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    cmp_count++;
    if (e !== s) begin n_fail++; $display("BAD %s exp %h got %h", n, e, s); end
  endtask
  task cyc(int n); repeat (n) @(posedge mclk); #1; endtask
  // one host io strobe, read when w is low
  task automatic io_op(logic w, logic [9:0] a, logic [7:0] d);
    @(posedge mclk) {io_wr, io_rd, io_addr, io_wdata} <= {w, !w, a, d};
    @(posedge mclk) {io_wr, io_rd} <= 2'h0;
    cyc(1);
  endtask
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watchdog on a hang
  initial
  begin
    repeat (3000) @(posedge mclk);
    n_fail++;
    tally_and_finish;
  end
  initial
  begin
    void'($urandom(32'h41382ba7));
    c = 8'($urandom());
    cyc(1);
    @(posedge mclk) reset <= 0;
    cyc(1);
    chk("gin", 24'hFFFFFF, general_input_state);
    chk("err", 1'h1, error_out_n);
    @(posedge mclk) forward_limit_in <= c;
    cyc(4);
    chk("flim", 8'(~c), fwd_limit_active);
    @(posedge mclk) {limit_pol, latch_pol, input_polarity_cmd, abort_in, local_reset_in_n} <= 5'h1C;
    @(posedge mclk) input_polarity_cmd <= 0;
    cyc(4);
    chk("flim_hi", c, fwd_limit_active);
    chk("rlim_hi", 8'hFF, rev_limit_active);
    chk("latch_hi", 8'hFF, latch_active);
    chk("home_lo", 8'h00, home_active);
    chk("abort", 1'h1, abort_active);
    chk("lrst", 1'h1, local_reset_out);
    chk("err_lrst", 1'h0, error_out_n);
    $display("test inputs done");
    @(posedge mclk) {motor_on_cmd, local_reset_in_n} <= 2'h3;
    @(posedge mclk) motor_on_cmd <= 0;
    cyc(3);
    chk("amp_on", 8'hFF, amp_enable_out);
    @(posedge mclk) {motor_off_cmd, motor_axis_mask} <= {1'h1, c};
    @(posedge mclk) motor_off_cmd <= 0;
    cyc(3);
    chk("amp_off", 8'(~c), amp_enable_out);
    chk("mcmd0", c[0] ? 16'h0 : 16'hFFFF, motor_command_voltage[15:0]);
    @(posedge mclk) {watchdog_timeout, pos_error_over} <= {1'h1, 8'h04};
    @(posedge mclk) watchdog_timeout <= 0;
    cyc(3);
    chk("amp_wd", 8'h00, amp_enable_out);
    chk("err_on", 1'h0, error_out_n);
    chk("led", 1'h1, error_led);
    @(posedge mclk) {off_on_error_enable_cmd, off_on_error_value, motor_axis_mask} <= 10'h3FF;
    @(posedge mclk) {off_on_error_enable_cmd, motor_on_cmd} <= 2'h1;
    @(posedge mclk) motor_on_cmd <= 0;
    cyc(2);
    chk("amp_oe", 8'hFB, amp_enable_out);
    $display("test amp done");
    @(posedge mclk) {out_cmd_port, out_cmd_byte, out_cmd_valid} <= {1'h1, c, 1'h1};
    out_cmd_op <= MIO_OUT_PORT;
    @(posedge mclk) out_cmd_bit <= 4'h2;
    out_cmd_op <= MIO_OUT_SET;
    @(posedge mclk) out_cmd_valid <= 0;
    cyc(3);
    chk("out_hi", c, general_output[15:8]);
    chk("out_lo", 8'h04, general_output[7:0]);
    chk("rdbk", {c, 8'h04}, output_port_readback);
    @(posedge mclk) num_axes <= 4'h4;
    cyc(3);
    chk("out_4ax", 8'h00, general_output[15:8]);
    chk("gin_4ax", 24'h00FFFF, general_input_state);
    @(posedge mclk) {adc_valid, adc_channel, adc_data} <= {1'h1, 3'h3, 4'h0, c};
    @(posedge mclk) adc_valid <= 0;
    cyc(1);
    chk("an3", {4'h0, c}, analog_channel[35:24]);
    $display("test outputs done");
    @(posedge mclk) {io_wdata, io_wr} <= {c, 1'h1};
    @(posedge mclk) io_wr <= 0;
    cyc(40);
    chk("cmd_char", c, got);
    @(posedge mclk) {send_data, send} <= {~c, 1'h1};
    @(posedge mclk) send <= 0;
    cyc(4);
    repeat (2)
    begin
      @(posedge mclk) io_rd <= 1;
      @(posedge mclk) io_rd <= 0;
      cyc(1);
      chk("rd", 8'(~c), io_rdata);
      c = 8'h00;
    end
    io_op(0, 10'h201, 8'h00);
    chk("ctl", 8'h20, io_rdata);
    repeat (2)
    begin
      io_op(1, 10'h201, 8'h01);
      io_op(1, 10'h201, 8'h80);
    end
    io_op(0, 10'h201, 8'h00);
    chk("clr", 8'hA0, io_rdata);
    chk("ovr", 1'h0, host_overrun);
    $display("test host done");
    tally_and_finish;
  end
endmodule
